// *** include/host_decode_regs.svh ***
`ifndef HOST_DECODE_REGS_SVH
`define HOST_DECODE_REGS_SVH

// first-phase request codes (logical level, bus inversion removed at the pins)
`define CODE_A_DEFER_REPLY 5'h00
`define CODE_A_RDINV       5'h02
`define CODE_A_CODE_RD     5'h04
`define CODE_A_WRITEBACK   5'h05
`define CODE_A_DATA_RD     5'h06
`define CODE_A_MEM_WR      5'h07
`define CODE_A_INTA_SPEC   5'h08
`define CODE_A_BTM         5'h09
`define CODE_A_IO_RD       5'h10
`define CODE_A_IO_WR       5'h11

// second-phase codes
`define CODE_B_INTA        5'h00
`define CODE_B_SPEC_LOW    3'h1

// field positions and legal values
`define ASIZE_MSB          4
`define ASIZE_LSB          3
`define ASIZE_32BIT        2'h0
`define LEN_8B           2'h0
`define LEN_16B          2'h1
`define LEN_32B          2'h2
`define BE_ALL           8'hFF

// response status codes
`define RESP_RETRY         3'h1
`define RESP_DEFER         3'h2
`define RESP_NO_DATA       3'h5
`define RESP_NORMAL_DATA   3'h7

// quadword index of the bridge configuration address/data ports
`define CFG_IO_QWORD     13'h019F

`endif

// *** include/host_decode_pkg.sv ***
package host_decode_pkg;

  typedef enum logic [3:0] {
    K_INTA, K_SPECIAL, K_BTM, K_IO_RD, K_IO_WR,
    K_RDINV, K_CODE_RD, K_DATA_RD, K_WRITEBACK, K_MEM_WR
  } kind_t;

  typedef enum logic [2:0] {
    T_DRAM, T_PCI_MEM, T_PCI_IO, T_CFG, T_LOCAL
  } target_t;

  typedef struct packed {
    kind_t       kind;
    target_t     target;
    logic [31:3] addr;
    logic [1:0]  len;
    logic [7:0]  be;
    logic [7:0]  subtype;
    logic        lock;
  } entry_t;

endpackage : host_decode_pkg

// *** logic/host_bus_request_decoder.sv ***
`timescale 1ns/1ns
`include "host_decode_regs.svh"
module host_bus_request_decoder #(
  parameter int          IOQ_DEPTH = 4,
  parameter logic [31:3] DRAM_TOP  = 29'h0100_0000
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        req_valid,
  output logic             req_ready,
  output logic             req_claimed,
  input  wire logic [4:0]  request_code_first_phase,
  input  wire logic [4:0]  request_code_second_phase,
  input  wire logic [31:3] req_addr,
  input  wire logic [7:0]  byte_lane_enables,
  input  wire logic [7:0]  second_phase_address_subtype,
  input  wire logic        req_lock,
  output logic             cmd_valid,
  input  wire logic        cmd_ready,
  output host_decode_pkg::kind_t   cmd_kind,
  output host_decode_pkg::target_t cmd_target,
  output logic [31:3]      cmd_addr,
  output logic [1:0]       cmd_len,
  output logic [7:0]       cmd_be,
  output logic [7:0]       cmd_subtype,
  input  wire logic        pci_busy,
  input  wire logic        dram_busy,
  input  wire logic        defer_enable,
  output logic             resp_valid,
  output logic [2:0]       response_status_code,
  input  wire logic        defer_reply_valid,
  output logic             defer_reply_ready,
  input  wire logic [31:3] defer_reply_addr,
  input  wire logic        pci_dram_wr_valid,
  output logic             pci_dram_wr_ready,
  input  wire logic        pci_dram_rd_valid,
  output logic             pci_dram_rd_ready,
  input  wire logic [31:3] pci_snoop_addr,
  output logic             issue_valid,
  input  wire logic        issue_ready,
  output logic [4:0]       issue_code,
  output logic [31:3]      issue_addr
);

  localparam int PW = $clog2(IOQ_DEPTH);

  function automatic logic is_mem_code(input logic [4:0] c);
    return c inside {`CODE_A_RDINV, `CODE_A_CODE_RD, `CODE_A_WRITEBACK,
                     `CODE_A_DATA_RD, `CODE_A_MEM_WR};
  endfunction : is_mem_code

  function automatic logic is_pci(input host_decode_pkg::target_t t);
    return t inside {host_decode_pkg::T_PCI_MEM, host_decode_pkg::T_PCI_IO};
  endfunction : is_pci

  // decode of the incoming request, both phases present together
  wire logic [4:0] code_a   = request_code_first_phase;
  wire logic [4:0] code_b   = request_code_second_phase;
  wire logic       len_ok   = (code_b[1:0] != `LEN_16B) && (code_b[1:0] != 2'h3);
  // only 32-bit addressing is decoded for memory codes; a wider size field on a memory code is left unclaimed
  wire logic       asize_ok = (code_a[`ASIZE_MSB:`ASIZE_LSB] == `ASIZE_32BIT);
  wire logic       in_dram  = (req_addr < DRAM_TOP);
  wire logic       cfg_hit  = (req_addr[15:3] == `CFG_IO_QWORD);
  wire logic       is_inta  = (code_a == `CODE_A_INTA_SPEC) && (code_b == `CODE_B_INTA);
  wire logic       is_spec  = (code_a == `CODE_A_INTA_SPEC) && (code_b[2:0] == `CODE_B_SPEC_LOW);
  wire logic       is_btm   = (code_a == `CODE_A_BTM) && (code_b == `CODE_B_INTA);
  wire logic       is_io    = (code_a == `CODE_A_IO_RD) || (code_a == `CODE_A_IO_WR);
  wire logic       is_mem   = is_mem_code(code_a) && asize_ok;
  wire logic       code_ok  = code_a != 5'h01 && code_a != 5'h03;
  // reserved combinations never reach the queue
  wire logic       valid_c  = is_inta || is_spec || is_btm ||
                              ((is_io || is_mem) && len_ok && code_ok);

  host_decode_pkg::kind_t   dec_kind;
  host_decode_pkg::target_t dec_target;

  always_comb begin
    dec_kind   = host_decode_pkg::K_MEM_WR;
    dec_target = in_dram ? host_decode_pkg::T_DRAM
                         : host_decode_pkg::T_PCI_MEM;
    if (is_inta) begin
      dec_kind   = host_decode_pkg::K_INTA;
      dec_target = host_decode_pkg::T_PCI_IO;
    end else if (is_spec) begin
      dec_kind   = host_decode_pkg::K_SPECIAL;
      dec_target = host_decode_pkg::T_LOCAL;
    end else if (is_btm) begin
      dec_kind   = host_decode_pkg::K_BTM;
      dec_target = host_decode_pkg::T_LOCAL;
    end else if (is_io) begin
      dec_kind   = (code_a == `CODE_A_IO_RD) ? host_decode_pkg::K_IO_RD
                                           : host_decode_pkg::K_IO_WR;
      dec_target = cfg_hit ? host_decode_pkg::T_CFG
                           : host_decode_pkg::T_PCI_IO;
    end else begin
      unique case (code_a)
        `CODE_A_RDINV:     dec_kind = host_decode_pkg::K_RDINV;
        `CODE_A_CODE_RD:   dec_kind = host_decode_pkg::K_CODE_RD;
        `CODE_A_DATA_RD:   dec_kind = host_decode_pkg::K_DATA_RD;
        `CODE_A_WRITEBACK: begin
          dec_kind   = host_decode_pkg::K_WRITEBACK;
          dec_target = host_decode_pkg::T_DRAM;
        end
        default:         dec_kind = host_decode_pkg::K_MEM_WR;
      endcase
    end
  end

  // in-order queue: pipelined requests wait here until completed in turn
  host_decode_pkg::entry_t ioq_q [IOQ_DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0]   count_q;
  host_decode_pkg::entry_t head;
  host_decode_pkg::entry_t new_entry;

  wire logic empty = (count_q == '0);
  wire logic full  = (count_q == (PW+1)'(IOQ_DEPTH));

  assign req_ready   = !full;
  assign req_claimed = req_valid && valid_c;
  wire logic push    = req_claimed && !full;

  always_comb begin
    new_entry.kind    = dec_kind;
    new_entry.target  = dec_target;
    new_entry.addr    = req_addr;
    // a 32-byte line always carries every lane
    new_entry.len     = code_b[1:0];
    new_entry.be      = (code_b[1:0] == `LEN_32B) ? `BE_ALL
                                                  : byte_lane_enables;
    new_entry.subtype = second_phase_address_subtype;
    new_entry.lock    = req_lock;
  end

  assign head = ioq_q[rd_ptr_q];

  // response selection at the head
  wire logic head_rd   = head.kind inside {host_decode_pkg::K_RDINV,
                         host_decode_pkg::K_CODE_RD, host_decode_pkg::K_DATA_RD,
                         host_decode_pkg::K_IO_RD, host_decode_pkg::K_INTA};
  wire logic lock_rd   = head.lock && head_rd && head.target == host_decode_pkg::T_DRAM;
  // writebacks sit in DRAM so the retry term can never catch them
  wire logic retry_now = !empty && ((pci_busy && is_pci(head.target)) ||
                         (dram_busy && lock_rd));
  wire logic defer_now = defer_enable && is_pci(head.target) &&
                         (head_rd || head.kind == host_decode_pkg::K_IO_WR);
  wire logic no_data   = !head_rd || head.kind == host_decode_pkg::K_BTM;
  // retry outranks defer: a busy resource must not be promised a later reply
  wire logic [2:0] resp_sel = retry_now ? `RESP_RETRY :
                              defer_now ? `RESP_DEFER :
                              no_data   ? `RESP_NO_DATA : `RESP_NORMAL_DATA;

  assign cmd_valid   = !empty && !retry_now;
  assign cmd_kind    = head.kind;
  assign cmd_target  = head.target;
  assign cmd_addr    = head.addr;
  assign cmd_len     = head.len;
  // branch trace data is dropped: lanes shown empty
  assign cmd_be      = (head.kind == host_decode_pkg::K_BTM) ? 8'h00 : head.be;
  assign cmd_subtype = head.subtype;
  wire logic pop     = !empty && (retry_now || cmd_ready);

  always_ff @(posedge mclk) begin
    if (push) begin
      ioq_q[wr_ptr_q] <= new_entry;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(IOQ_DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(IOQ_DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      resp_valid           <= 1'b0;
      response_status_code <= 3'h0;
    end else begin
      resp_valid           <= pop;
      response_status_code <= pop ? resp_sel : 3'h0;
    end
  end

  // outgoing transactions driven by this device; deferred reply first so
  // the processor's pending transaction is not starved by snoop traffic
  wire logic slot_free = !issue_valid || issue_ready;
  assign defer_reply_ready = slot_free;
  assign pci_dram_wr_ready = slot_free && !defer_reply_valid;
  assign pci_dram_rd_ready = slot_free && !defer_reply_valid && !pci_dram_wr_valid;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      issue_valid <= 1'b0;
      issue_code  <= 5'h00;
      issue_addr  <= '0;
    end else if (slot_free) begin
      issue_valid <= defer_reply_valid || pci_dram_wr_valid || pci_dram_rd_valid;
      if (defer_reply_valid) begin
        issue_code <= `CODE_A_DEFER_REPLY;
        issue_addr <= defer_reply_addr;
      end else if (pci_dram_wr_valid) begin
        issue_code <= `CODE_A_RDINV;
        issue_addr <= pci_snoop_addr;
      end else if (pci_dram_rd_valid) begin
        issue_code <= `CODE_A_DATA_RD;
        issue_addr <= pci_snoop_addr;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_retry_pop;
    pop && retry_now;
  endsequence

  // an issue the processor has not taken yet must keep code and address
  sequence s_issue_stalled;
    issue_valid && !issue_ready;
  endsequence

  sequence s_issue_same;
    issue_valid && $stable(issue_code) && $stable(issue_addr);
  endsequence

  chk_order_pop: assert property (pop |=> rd_ptr_q != $past(rd_ptr_q) || IOQ_DEPTH == 1)
    else $error("queue head did not advance on completion");
  chk_retry_resp: assert property (s_retry_pop |=> resp_valid && response_status_code == `RESP_RETRY)
    else $error("retry not reported");
  chk_wb_noretry: assert property (pop && head.kind == host_decode_pkg::K_WRITEBACK |=>
                                   response_status_code != `RESP_RETRY)
    else $error("writeback retried");
  chk_wb_dram: assert property (push && code_a == `CODE_A_WRITEBACK |->
                                new_entry.target == host_decode_pkg::T_DRAM)
    else $error("writeback not sent to DRAM");
  chk_defer_resp: assert property (pop && !retry_now && defer_now |=>
                                   response_status_code == `RESP_DEFER)
    else $error("deferred response missing");
  chk_inta_pci: assert property (push && is_inta |-> new_entry.target == host_decode_pkg::T_PCI_IO)
    else $error("interrupt ack not sent to PCI");
  chk_btm_nodata: assert property (cmd_valid && cmd_kind == host_decode_pkg::K_BTM |-> cmd_be == 8'h00)
    else $error("branch trace data kept");
  chk_full_hold: assert property (full |=> count_q == $past(count_q) - (PW+1)'($past(pop)))
    else $error("request queued while full");
  chk_issue_hold: assert property (s_issue_stalled |=> s_issue_same)
    else $error("stalled issue changed");
  chk_reserved_drop: assert property (req_valid && !valid_c |=> count_q == $past(count_q) -
                                      (PW+1)'($past(pop)))
    else $error("reserved request changed queue");
  chk_pipe_accept: assert property (push && !pop && !empty |=> count_q == $past(count_q) + 1'b1)
    else $error("pipelined request lost");
  chk_cfg_local: assert property (push && is_io && cfg_hit |->
                                  new_entry.target == host_decode_pkg::T_CFG)
    else $error("config I/O forwarded");
  chk_defer_code: assert property (defer_reply_valid && defer_reply_ready |=>
                                   issue_valid && issue_code == `CODE_A_DEFER_REPLY)
    else $error("deferred reply not issued");
  chk_snoop_wr: assert property (pci_dram_wr_valid && pci_dram_wr_ready |=>
                                 issue_valid && issue_code == `CODE_A_RDINV)
    else $error("write snoop code wrong");
  chk_snoop_rd: assert property (pci_dram_rd_valid && pci_dram_rd_ready |=>
                                 issue_code == `CODE_A_DATA_RD)
    else $error("read snoop code wrong");
  chk_line_lanes: assert property (push && code_b[1:0] == `LEN_32B |-> new_entry.be == `BE_ALL)
    else $error("line transfer lanes incomplete");
  chk_asize_only: assert property (push && is_mem_code(code_a) |-> asize_ok)
    else $error("wide address size claimed");

endmodule : host_bus_request_decoder

// *** testbench/cpu_model.sv ***
`timescale 1ns/1ns
module cpu_model (
  input  wire logic        mclk,
  input  wire logic        req_ready,
  input  wire logic        req_claimed,
  input  wire logic        issue_stall,
  output logic             req_valid,
  output logic [4:0]       request_code_first_phase,
  output logic [4:0]       request_code_second_phase,
  output logic [31:3]      req_addr,
  output logic [7:0]       byte_lane_enables,
  output logic [7:0]       second_phase_address_subtype,
  output logic             req_lock,
  output logic             issue_ready
);
  logic cl;
  // a stalled processor leaves snoop issues standing on the bus
  assign issue_ready = ~issue_stall;
  initial begin
    req_valid = 1'b0;
    {request_code_first_phase, request_code_second_phase, req_addr} = '0;
    {byte_lane_enables, second_phase_address_subtype, req_lock, cl} = '0;
  end
  task automatic send(input logic [4:0] a, b, input logic [31:3] ad, input logic [7:0] be, sub, input logic lk);
    logic rdy;
    req_valid = 1'b1;
    request_code_first_phase = a;
    request_code_second_phase = b;
    req_addr = ad;
    byte_lane_enables = be;
    second_phase_address_subtype = sub;
    req_lock = lk;
    // both phases held until the edge that takes them, or one edge if refused
    do begin
      @(negedge mclk);
      rdy = req_ready;
      cl = req_claimed;
      @(posedge mclk);
    end while (!rdy && cl);
    #1;
  endtask : send
  task automatic idle;
    // released code, address and lane lines show the inverse so stale values cannot pass
    req_valid = 1'b0;
    request_code_first_phase = ~request_code_first_phase;
    request_code_second_phase = ~request_code_second_phase;
    req_addr = ~req_addr;
    byte_lane_enables = ~byte_lane_enables;
  endtask : idle
endmodule : cpu_model

// *** testbench/tb_host_bus_request_decoder.sv ***
`timescale 1ns/1ns
`include "host_decode_regs.svh"
module tb_host_bus_request_decoder;
  localparam logic [31:3] DT = 29'h0100_0000;
  logic mclk, arst_n, req_valid, req_ready, req_claimed, req_lock, cmd_valid, cmd_ready, pci_busy, dram_busy;
  logic defer_enable, resp_valid, defer_reply_valid, defer_reply_ready, pci_dram_wr_valid, pci_dram_wr_ready;
  logic pci_dram_rd_valid, pci_dram_rd_ready, issue_valid, issue_ready, issue_stall;
  logic [4:0] request_code_first_phase, request_code_second_phase, issue_code;
  logic [31:3] req_addr, cmd_addr, defer_reply_addr, pci_snoop_addr, issue_addr;
  logic [7:0] byte_lane_enables, second_phase_address_subtype, cmd_be, cmd_subtype;
  logic [1:0] cmd_len;
  logic [2:0] response_status_code;
  host_decode_pkg::kind_t cmd_kind;
  host_decode_pkg::target_t cmd_target;
  int err_total, cmp_count, cyc;
  host_bus_request_decoder #(.IOQ_DEPTH(4), .DRAM_TOP(DT)) i_dut (.mclk, .arst_n, .req_valid, .req_ready,
    .req_claimed, .request_code_first_phase, .request_code_second_phase, .req_addr, .byte_lane_enables,
    .second_phase_address_subtype, .req_lock, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_target, .cmd_addr,
    .cmd_len, .cmd_be, .cmd_subtype, .pci_busy, .dram_busy, .defer_enable, .resp_valid, .response_status_code,
    .defer_reply_valid, .defer_reply_ready, .defer_reply_addr, .pci_dram_wr_valid, .pci_dram_wr_ready,
    .pci_dram_rd_valid, .pci_dram_rd_ready, .pci_snoop_addr, .issue_valid, .issue_ready, .issue_code, .issue_addr);
  cpu_model i_cpu (.mclk, .req_ready, .req_claimed, .issue_stall, .req_valid, .request_code_first_phase,
    .request_code_second_phase, .req_addr, .byte_lane_enables, .second_phase_address_subtype, .req_lock,
    .issue_ready);
  always #50 mclk = ~mclk;
  task automatic wrap_up;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic step;
    @(posedge mclk);
    #1;
  endtask : step
  // target 7 and status 0 mean the value is not judged
  task automatic xact(input logic [4:0] a, b, input logic [31:3] ad, input logic [7:0] be, sub, input logic lk,
                      input logic [3:0] k, input logic [2:0] t, st, input logic [7:0] ebe);
    int n;
    i_cpu.send(a, b, ad, be, sub, lk);
    i_cpu.idle();
    chk("cmd_valid_first", st != 3'h1, cmd_valid);
    for (n = 0; n < 12 && resp_valid !== 1'b1; n++) begin
      if (cmd_valid === 1'b1 && cmd_ready !== 1'b1) begin
        chk("cmd_valid", st != 3'h1, 1'b1);
        chk("cmd_kind", k, cmd_kind);
        if (t != 3'h7) chk("cmd_target", t, cmd_target);
        chk("cmd_addr", ad, cmd_addr);
        chk("cmd_len", b[1:0], cmd_len);
        chk("cmd_be", ebe, cmd_be);
        if (k == host_decode_pkg::K_SPECIAL) chk("cmd_subtype", sub, cmd_subtype);
        cmd_ready = 1'b1;
      end
      step();
    end
    chk("resp_valid", 1, resp_valid);
    if (st != 3'h0) chk("response_status_code", st, response_status_code);
    cmd_ready = 1'b0;
    step();
    chk("resp_valid_pulse", 0, resp_valid);
  endtask : xact
  task automatic t_route;
    logic [4:0] mc [4] = '{`CODE_A_RDINV, `CODE_A_CODE_RD, `CODE_A_DATA_RD, `CODE_A_MEM_WR};
    host_decode_pkg::kind_t mk [4] = '{host_decode_pkg::K_RDINV, host_decode_pkg::K_CODE_RD,
                                       host_decode_pkg::K_DATA_RD, host_decode_pkg::K_MEM_WR};
    int i;
    for (i = 0; i < 4; i++) begin
      xact(mc[i], 5'h02, 29'h10 + i, 8'h0F, 8'h00, 1'b0, mk[i], host_decode_pkg::T_DRAM, (i == 3) ? 3'h5 : 3'h7,
           8'hFF);
      xact(mc[i], 5'h00, DT + i, 8'h0F, 8'h00, 1'b0, mk[i], host_decode_pkg::T_PCI_MEM, (i == 3) ? 3'h5 : 3'h7,
           8'h0F);
    end
  endtask : t_route
  task automatic t_io;
    xact(`CODE_A_IO_RD, 5'h00, 29'h40, 8'h01, 8'h00, 1'b0, host_decode_pkg::K_IO_RD, host_decode_pkg::T_PCI_IO,
         3'h7, 8'h01);
    xact(`CODE_A_IO_WR, 5'h00, 29'h41, 8'h03, 8'h00, 1'b0, host_decode_pkg::K_IO_WR, host_decode_pkg::T_PCI_IO,
         3'h5, 8'h03);
    xact(`CODE_A_IO_RD, 5'h00, `CFG_IO_QWORD, 8'hF0, 8'h00, 1'b0, host_decode_pkg::K_IO_RD, host_decode_pkg::T_CFG,
         3'h7, 8'hF0);
    xact(`CODE_A_IO_WR, 5'h00, `CFG_IO_QWORD, 8'h0F, 8'h00, 1'b0, host_decode_pkg::K_IO_WR, host_decode_pkg::T_CFG,
         3'h5, 8'h0F);
  endtask : t_io
  task automatic t_spec;
    xact(`CODE_A_INTA_SPEC, 5'h00, 29'h0, 8'hFF, 8'h00, 1'b0, host_decode_pkg::K_INTA, host_decode_pkg::T_PCI_IO,
         3'h7, 8'hFF);
    xact(`CODE_A_INTA_SPEC, 5'h19, 29'h0, 8'h03, 8'hA5, 1'b0, host_decode_pkg::K_SPECIAL, host_decode_pkg::T_LOCAL,
         3'h5, 8'h03);
    xact(`CODE_A_BTM, 5'h00, 29'h20, 8'hFF, 8'h00, 1'b0, host_decode_pkg::K_BTM, host_decode_pkg::T_LOCAL, 3'h5,
         8'h00);
  endtask : t_spec
  task automatic t_resv;
    logic [9:0] tb [10] = '{{5'h01, 5'h00}, {5'h03, 5'h00}, {5'h08, 5'h02}, {5'h08, 5'h04}, {5'h09, 5'h01},
                            {5'h18, 5'h00}, {5'h0A, 5'h00}, {5'h06, 5'h01}, {5'h00, 5'h00}, {5'h10, 5'h03}};
    int i;
    for (i = 0; i < 10; i++) begin
      i_cpu.send(tb[i][9:5], tb[i][4:0], 29'h10, 8'hFF, 8'h00, 1'b0);
      i_cpu.idle();
      chk("req_claimed", 0, i_cpu.cl);
      step();
      chk("cmd_valid_refused", 0, cmd_valid);
    end
  endtask : t_resv
  task automatic t_fill;
    int i;
    for (i = 1; i <= 4; i++) i_cpu.send(`CODE_A_DATA_RD, 5'h00, 29'(i), 8'hFF, 8'h00, 1'b0);
    i_cpu.idle();
    chk("req_ready_full", 0, req_ready);
    cmd_ready = 1'b1;
    for (i = 1; i <= 4; i++) begin
      chk("cmd_addr_order", i, cmd_addr);
      step();
    end
    cmd_ready = 1'b0;
    repeat (2) step();
  endtask : t_fill
  task automatic t_retry;
    pci_busy = 1'b1;
    dram_busy = 1'b1;
    xact(`CODE_A_MEM_WR, 5'h00, DT + 5, 8'hFF, 8'h00, 1'b0, host_decode_pkg::K_MEM_WR, 3'h7, 3'h1,
         8'hFF);
    xact(`CODE_A_DATA_RD, 5'h00, 29'h30, 8'hFF, 8'h00, 1'b1, host_decode_pkg::K_DATA_RD, 3'h7, 3'h1,
         8'hFF);
    xact(`CODE_A_WRITEBACK, 5'h02, DT + 6, 8'hFF, 8'h00, 1'b0, host_decode_pkg::K_WRITEBACK, host_decode_pkg::T_DRAM,
         3'h5, 8'hFF);
    pci_busy = 1'b0;
    dram_busy = 1'b0;
  endtask : t_retry
  task automatic t_defer;
    defer_enable = 1'b1;
    xact(`CODE_A_DATA_RD, 5'h00, DT + 7, 8'hFF, 8'h00, 1'b0, host_decode_pkg::K_DATA_RD, host_decode_pkg::T_PCI_MEM,
         3'h2, 8'hFF);
    xact(`CODE_A_IO_WR, 5'h00, 29'h42, 8'h01, 8'h00, 1'b0, host_decode_pkg::K_IO_WR, host_decode_pkg::T_PCI_IO,
         3'h2, 8'h01);
    defer_enable = 1'b0;
  endtask : t_defer
  task automatic t_issue(input int s, input logic [4:0] ec);
    logic rdy;
    issue_stall = 1'b1;
    defer_reply_addr = 29'h123 + s;
    pci_snoop_addr = 29'h123 + s;
    {pci_dram_rd_valid, pci_dram_wr_valid, defer_reply_valid} = 3'b1 << s;
    do begin
      @(negedge mclk);
      rdy = (s == 0) ? defer_reply_ready : (s == 1) ? pci_dram_wr_ready : pci_dram_rd_ready;
      @(posedge mclk);
    end while (!rdy);
    #1;
    {pci_dram_rd_valid, pci_dram_wr_valid, defer_reply_valid} = 3'b000;
    chk("issue_valid", 1, issue_valid);
    chk("issue_code", ec, issue_code);
    chk("issue_addr", 29'h123 + s, issue_addr);
    repeat (2) step();
    chk("issue_valid_stall", 1, issue_valid);
    issue_stall = 1'b0;
    step();
    chk("issue_valid_done", 0, issue_valid);
  endtask : t_issue
  initial begin
    {mclk, arst_n, cmd_ready, pci_busy, dram_busy, defer_enable, issue_stall} = '0;
    {defer_reply_valid, pci_dram_wr_valid, pci_dram_rd_valid, defer_reply_addr, pci_snoop_addr} = '0;
    repeat (3) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    chk("req_ready_reset", 1, req_ready);
    chk("cmd_valid_reset", 0, cmd_valid);
    t_route();
    t_io();
    t_spec();
    t_resv();
    t_fill();
    t_retry();
    t_defer();
    t_issue(0, `CODE_A_DEFER_REPLY);
    t_issue(1, `CODE_A_RDINV);
    t_issue(2, `CODE_A_DATA_RD);
    wrap_up();
  end
endmodule : tb_host_bus_request_decoder
